// ---- hdl/lfs_pkg.sv ----
package lfs_pkg;

    localparam int CLK_FREQ_KHZ = 25000;

    // Soft-start ramp times, typical, in ms
    localparam real SS_TIME_MS_0 = 1.75;
    localparam real SS_TIME_MS_1 = 10.5;
    localparam real SS_TIME_MS_2 = 21.0;
    localparam real SS_TIME_MS_3 = 40.2;
    localparam int SS_CYC_0 = $rtoi(SS_TIME_MS_0 * CLK_FREQ_KHZ + 0.5);
    localparam int SS_CYC_1 = $rtoi(SS_TIME_MS_1 * CLK_FREQ_KHZ + 0.5);
    localparam int SS_CYC_2 = $rtoi(SS_TIME_MS_2 * CLK_FREQ_KHZ + 0.5);
    localparam int SS_CYC_3 = $rtoi(SS_TIME_MS_3 * CLK_FREQ_KHZ + 0.5);

    // Ramp end point as a fraction of full_scale_span
    localparam int SS_TARGET_NUM = 2;
    localparam int SS_TARGET_DEN = 3;

    // Gain steps in tenths of a dB
    localparam logic [7:0] GAIN_STEP_TENTH_DB = 8'h03;
    localparam logic [7:0] GAIN_SPAN_TENTH_DB = 8'hc8;
    localparam logic [7:0] GAIN_CODE_MAX = 8'h42;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CHA_SS_RAMP = 16'hfe2a;
    localparam logic [15:0] IDX_CHB_SS_RAMP = 16'hfe2b;
    localparam logic [15:0] IDX_CHA_NORM_LF_GAIN = 16'hfe2c;
    localparam logic [15:0] IDX_CHB_NORM_LF_GAIN = 16'hfe2d;
    localparam logic [15:0] IDX_CHA_NORM_ZERO = 16'hfe2e;
    localparam logic [15:0] IDX_CHB_NORM_ZERO = 16'hfe2f;
    localparam logic [15:0] IDX_CHA_NORM_POLE = 16'hfe30;
    localparam logic [15:0] IDX_CHB_NORM_POLE = 16'hfe31;
    localparam logic [15:0] IDX_CHA_NORM_HF_GAIN = 16'hfe32;
    localparam logic [15:0] IDX_CHB_NORM_HF_GAIN = 16'hfe33;
    localparam logic [15:0] IDX_CHA_LL_LF_GAIN = 16'hfe34;
    localparam logic [15:0] IDX_CHB_LL_LF_GAIN = 16'hfe35;
    localparam logic [15:0] IDX_STATUS = 16'hfe50;

    // Storage slots: slot = channel + 2 * field
    localparam int NUM_CHAN = 2;
    localparam int NUM_SLOT = 12;
    localparam int FLD_SS = 0;
    localparam int FLD_LF = 1;
    localparam int FLD_ZERO = 2;
    localparam int FLD_POLE = 3;
    localparam int FLD_HF = 4;
    localparam int FLD_LL_LF = 5;

    // Soft-start ramp field
    localparam int SS_CODE_LSB = 0;
    localparam int SS_CODE_W = 2;

    // Status register bit positions
    localparam int ST_BUSY_LSB = 0;
    localparam int ST_DONE_LSB = 2;
    localparam int ST_LL_LSB = 4;
    localparam int ST_GERR_LSB = 6;

    localparam logic [7:0] CFG_RESET = 8'h00;

    typedef enum logic [1:0] {
        LFS_SS_IDLE,
        LFS_SS_RAMP,
        LFS_SS_HOLD
    } lfs_ss_state_e;

endpackage

// ---- hdl/lfs_loop_filter_cfg.sv ----
`timescale 1ns/1ns
module lfs_loop_filter_cfg #(
    parameter int REF_W = 12,
    parameter int SS_CYC_0 = lfs_pkg::SS_CYC_0,
    parameter int SS_CYC_1 = lfs_pkg::SS_CYC_1,
    parameter int SS_CYC_2 = lfs_pkg::SS_CYC_2,
    parameter int SS_CYC_3 = lfs_pkg::SS_CYC_3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic light_load_a,
    input wire logic light_load_b,
    input wire logic ss_start_a,
    input wire logic ss_start_b,
    input wire logic ss_stop_a,
    input wire logic ss_stop_b,
    output logic [REF_W-1:0] ss_ref_a,
    output logic [REF_W-1:0] ss_ref_b,
    output logic ss_busy_a,
    output logic ss_busy_b,
    output logic ss_done_a,
    output logic ss_done_b,
    output logic [7:0] lf_gain_a,
    output logic [7:0] lf_gain_b,
    output logic [7:0] lf_gain_tenth_db_a,
    output logic [7:0] lf_gain_tenth_db_b,
    output logic [7:0] zero_pos_a,
    output logic [7:0] zero_pos_b,
    output logic [7:0] pole_pos_a,
    output logic [7:0] pole_pos_b,
    output logic [7:0] hf_gain_a,
    output logic [7:0] hf_gain_b,
    output logic [7:0] hf_gain_tenth_db_a,
    output logic [7:0] hf_gain_tenth_db_b,
    output logic gain_err_a,
    output logic gain_err_b
);

    localparam int FULL_SCALE = (1 << REF_W) - 1;
    localparam int SS_TARGET = FULL_SCALE * lfs_pkg::SS_TARGET_NUM / lfs_pkg::SS_TARGET_DEN;
    localparam int SS_PER_0 = (SS_CYC_0 / SS_TARGET < 1) ? 1 : SS_CYC_0 / SS_TARGET;
    localparam int SS_PER_1 = (SS_CYC_1 / SS_TARGET < 1) ? 1 : SS_CYC_1 / SS_TARGET;
    localparam int SS_PER_2 = (SS_CYC_2 / SS_TARGET < 1) ? 1 : SS_CYC_2 / SS_TARGET;
    localparam int SS_PER_3 = (SS_CYC_3 / SS_TARGET < 1) ? 1 : SS_CYC_3 / SS_TARGET;
    localparam logic [REF_W-1:0] SS_TARGET_V = REF_W'(SS_TARGET);
    localparam logic [REF_W-1:0] REF_ZERO = '0;
    localparam logic [REF_W-1:0] REF_ONE = REF_W'(1);
    localparam logic [23:0] DIV_ONE = 24'h000001;

    // Maps a register index onto a storage slot
    function automatic logic [4:0] slot_of(input logic [15:0] idx);
        logic [15:0] rel;
        rel = idx - lfs_pkg::IDX_CHA_SS_RAMP;
        if (idx >= lfs_pkg::IDX_CHA_SS_RAMP && rel < 16'(lfs_pkg::NUM_SLOT)) begin
            slot_of = {1'b1, rel[3:0]};
        end else begin
            slot_of = 5'h00;
        end
    endfunction

    // Cycles between reference steps for a ramp code
    function automatic logic [23:0] ss_period(input logic [1:0] code);
        case (code)
            2'h0: ss_period = 24'(SS_PER_0);
            2'h1: ss_period = 24'(SS_PER_1);
            2'h2: ss_period = 24'(SS_PER_2);
            default: ss_period = 24'(SS_PER_3);
        endcase
    endfunction

    // Flags a gain code beyond the defined span
    function automatic logic gain_over(input logic [7:0] code);
        gain_over = (code > lfs_pkg::GAIN_CODE_MAX);
    endfunction

    // Clamps a gain code to the defined span
    function automatic logic [7:0] gain_clamp(input logic [7:0] code);
        gain_clamp = gain_over(code) ? lfs_pkg::GAIN_CODE_MAX : code;
    endfunction

    logic [7:0] cfg_reg [lfs_pkg::NUM_SLOT];
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [15:0] bus_idx;
    logic [4:0] bus_slot;
    logic cfg_hit;
    logic status_hit;
    logic rd_take;
    logic wr_cfg;
    logic [7:0] status;
    logic [7:0] rd_byte;
    logic [1:0] light_load;
    logic [1:0] ss_start;
    logic [1:0] ss_stop;
    logic [1:0] busy;
    logic [1:0] done;
    logic [1:0] gerr;
    logic [REF_W-1:0] ref_out [lfs_pkg::NUM_CHAN];
    logic [7:0] lf_out [lfs_pkg::NUM_CHAN];
    logic [7:0] lf_db_out [lfs_pkg::NUM_CHAN];
    logic [7:0] zero_out [lfs_pkg::NUM_CHAN];
    logic [7:0] pole_out [lfs_pkg::NUM_CHAN];
    logic [7:0] hf_out [lfs_pkg::NUM_CHAN];
    logic [7:0] hf_db_out [lfs_pkg::NUM_CHAN];

    assign bus_idx = avs_address[17:2];
    assign bus_slot = slot_of(bus_idx);
    assign light_load = {light_load_b, light_load_a};
    assign ss_start = {ss_start_b, ss_start_a};
    assign ss_stop = {ss_stop_b, ss_stop_a};

    // Address decode: slot hit shared by the read and write paths, status hit used by reads only
    assign cfg_hit = bus_slot[4];
    assign status_hit = (bus_idx == lfs_pkg::IDX_STATUS);

    // Bus slave: one wait cycle, then the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata = rdata_reg;

    // Read capture in the wait cycle, write on the acknowledge edge
    assign rd_take = avs_read & ~ack_reg;
    assign wr_cfg = avs_write & ack_reg & avs_byteenable[0] & cfg_hit;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else if ((avs_read | avs_write) & ~ack_reg) begin
            ack_reg <= 1'b1;
        end else begin
            ack_reg <= 1'b0;
        end
    end

    // Status byte built from its field positions
    always_comb begin
        status = 8'h00;
        status[lfs_pkg::ST_BUSY_LSB +: lfs_pkg::NUM_CHAN] = busy;
        status[lfs_pkg::ST_DONE_LSB +: lfs_pkg::NUM_CHAN] = done;
        status[lfs_pkg::ST_LL_LSB +: lfs_pkg::NUM_CHAN] = light_load;
        status[lfs_pkg::ST_GERR_LSB +: lfs_pkg::NUM_CHAN] = gerr;
    end

    // Read byte for the addressed register
    always_comb begin
        rd_byte = 8'h00;
        if (cfg_hit) begin
            rd_byte = cfg_reg[bus_slot[3:0]];
        end else if (status_hit) begin
            rd_byte = status;
        end
    end

    // Read data are captured in the wait cycle and held until the next read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_take) begin
            rdata_reg <= {24'h000000, rd_byte};
        end
    end

    // Configuration store; a write lands on the acknowledge edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < lfs_pkg::NUM_SLOT; i++) begin
                cfg_reg[i] <= lfs_pkg::CFG_RESET;
            end
        end else if (wr_cfg) begin
            // Whole byte kept, reserved ramp bits included
            cfg_reg[bus_slot[3:0]] <= avs_writedata[7:0];
        end
    end

    generate
        for (genvar ch = 0; ch < lfs_pkg::NUM_CHAN; ch++) begin : g_ch
            localparam int S_SS = ch + 2 * lfs_pkg::FLD_SS;
            localparam int S_LF = ch + 2 * lfs_pkg::FLD_LF;
            localparam int S_ZERO = ch + 2 * lfs_pkg::FLD_ZERO;
            localparam int S_POLE = ch + 2 * lfs_pkg::FLD_POLE;
            localparam int S_HF = ch + 2 * lfs_pkg::FLD_HF;
            localparam int S_LL = ch + 2 * lfs_pkg::FLD_LL_LF;

            lfs_pkg::lfs_ss_state_e state_reg;
            logic [REF_W-1:0] ref_reg;
            logic [23:0] div_reg;
            logic [23:0] per_reg;
            logic done_reg;
            logic tick;
            logic [7:0] lf_sel;
            logic [7:0] lf_reg;
            logic [7:0] lf_db_reg;
            logic [7:0] zero_reg;
            logic [7:0] pole_reg;
            logic [7:0] hf_reg;
            logic [7:0] hf_db_reg;
            logic gerr_reg;
            logic [1:0] ss_code;
            logic [23:0] per_sel;
            logic [REF_W-1:0] ref_inc;
            logic at_target;
            logic [7:0] lf_clamp;
            logic [7:0] hf_clamp;

            // Step enable from the ramp-rate divider
            assign tick = (state_reg == lfs_pkg::LFS_SS_RAMP) && (div_reg == DIV_ONE);

            // Ramp period for the code now in the register
            assign ss_code = cfg_reg[S_SS][lfs_pkg::SS_CODE_LSB +: lfs_pkg::SS_CODE_W];
            assign per_sel = ss_period(ss_code);

            // Next reference step and end-of-ramp test
            assign ref_inc = ref_reg + REF_ONE;
            assign at_target = (ref_inc == SS_TARGET_V);

            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    div_reg <= DIV_ONE;
                end else if (ss_start[ch] || tick) begin
                    div_reg <= ss_start[ch] ? per_sel : per_reg;
                end else if (state_reg == lfs_pkg::LFS_SS_RAMP) begin
                    div_reg <= div_reg - DIV_ONE;
                end
            end

            // Ramp period is sampled at start so a rewrite waits for the next ramp
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    per_reg <= DIV_ONE;
                end else if (ss_start[ch]) begin
                    per_reg <= per_sel;
                end
            end

            // Soft-start sequencer: stop wins over start
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    state_reg <= lfs_pkg::LFS_SS_IDLE;
                    ref_reg <= REF_ZERO;
                    done_reg <= 1'b0;
                end else if (ss_stop[ch]) begin
                    state_reg <= lfs_pkg::LFS_SS_IDLE;
                    ref_reg <= REF_ZERO;
                    done_reg <= 1'b0;
                end else if (ss_start[ch]) begin
                    state_reg <= lfs_pkg::LFS_SS_RAMP;
                    ref_reg <= REF_ZERO;
                    done_reg <= 1'b0;
                end else begin
                    case (state_reg)
                        lfs_pkg::LFS_SS_IDLE: begin
                            ref_reg <= REF_ZERO;
                        end
                        lfs_pkg::LFS_SS_RAMP: begin
                            if (tick) begin
                                ref_reg <= ref_inc;
                                if (at_target) begin
                                    state_reg <= lfs_pkg::LFS_SS_HOLD;
                                    done_reg <= 1'b1;
                                end
                            end
                        end
                        lfs_pkg::LFS_SS_HOLD: begin
                            ref_reg <= SS_TARGET_V;
                        end
                        default: begin
                            state_reg <= lfs_pkg::LFS_SS_IDLE;
                        end
                    endcase
                end
            end

            // Light-load indication from outside picks the LF gain slot; HF gain, zero and pole stay unchanged
            assign lf_sel = light_load[ch] ? cfg_reg[S_LL] : cfg_reg[S_LF];

            // Gain codes limited to the defined span
            assign lf_clamp = gain_clamp(lf_sel);
            assign hf_clamp = gain_clamp(cfg_reg[S_HF]);

            // Applied coefficients, one channel's slots only
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    lf_reg <= lfs_pkg::CFG_RESET;
                    zero_reg <= lfs_pkg::CFG_RESET;
                    pole_reg <= lfs_pkg::CFG_RESET;
                    hf_reg <= lfs_pkg::CFG_RESET;
                end else begin
                    lf_reg <= lf_clamp;
                    zero_reg <= cfg_reg[S_ZERO];
                    pole_reg <= cfg_reg[S_POLE];
                    hf_reg <= hf_clamp;
                end
            end

            // Gain in tenths of a dB and out-of-span flag
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    lf_db_reg <= 8'h00;
                    hf_db_reg <= 8'h00;
                    gerr_reg <= 1'b0;
                end else begin
                    lf_db_reg <= 8'(lf_clamp * lfs_pkg::GAIN_STEP_TENTH_DB);
                    hf_db_reg <= 8'(hf_clamp * lfs_pkg::GAIN_STEP_TENTH_DB);
                    gerr_reg <= gain_over(lf_sel) || gain_over(cfg_reg[S_HF]);
                end
            end

            assign busy[ch] = (state_reg == lfs_pkg::LFS_SS_RAMP);
            assign done[ch] = done_reg;
            assign gerr[ch] = gerr_reg;
            assign ref_out[ch] = ref_reg;
            assign lf_out[ch] = lf_reg;
            assign lf_db_out[ch] = lf_db_reg;
            assign zero_out[ch] = zero_reg;
            assign pole_out[ch] = pole_reg;
            assign hf_out[ch] = hf_reg;
            assign hf_db_out[ch] = hf_db_reg;
        end
    endgenerate

    assign ss_ref_a = ref_out[0];
    assign ss_ref_b = ref_out[1];
    assign ss_busy_a = busy[0];
    assign ss_busy_b = busy[1];
    assign ss_done_a = done[0];
    assign ss_done_b = done[1];
    assign lf_gain_a = lf_out[0];
    assign lf_gain_b = lf_out[1];
    assign lf_gain_tenth_db_a = lf_db_out[0];
    assign lf_gain_tenth_db_b = lf_db_out[1];
    assign zero_pos_a = zero_out[0];
    assign zero_pos_b = zero_out[1];
    assign pole_pos_a = pole_out[0];
    assign pole_pos_b = pole_out[1];
    assign hf_gain_a = hf_out[0];
    assign hf_gain_b = hf_out[1];
    assign hf_gain_tenth_db_a = hf_db_out[0];
    assign hf_gain_tenth_db_b = hf_db_out[1];
    assign gain_err_a = gerr[0];
    assign gain_err_b = gerr[1];

endmodule

// ---- tb/lfs_loop_filter_cfg_assertions.sv ----
`timescale 1ns/1ns
module lfs_loop_filter_cfg_assertions #(
    parameter int REF_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic ss_start_a,
    input wire logic ss_stop_a,
    input wire logic ss_start_b,
    input wire logic ss_stop_b,
    input wire logic [REF_W-1:0] ss_ref_a,
    input wire logic [REF_W-1:0] ss_ref_b,
    input wire logic ss_busy_a,
    input wire logic ss_busy_b,
    input wire logic ss_done_a,
    input wire logic [7:0] lf_gain_a,
    input wire logic [7:0] lf_gain_tenth_db_a,
    input wire logic [7:0] hf_gain_b,
    input wire logic [7:0] hf_gain_tenth_db_b
);
    localparam int TGT = ((2 ** REF_W) - 1) * 2 / 3;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_wait;
        avs_waitrequest;
    endsequence
    sequence s_go;
        !avs_waitrequest;
    endsequence
    chk_bus_wait_once: assert property ($rose(avs_read || avs_write) |-> s_wait ##1 s_go)
        else $error("bus answer not after one wait cycle");
    chk_lf_tenth_db: assert property (lf_gain_tenth_db_a == lf_gain_a * 8'h03)
        else $error("lf gain in tenth dB wrong");
    chk_hf_tenth_db: assert property (hf_gain_tenth_db_b == hf_gain_b * 8'h03)
        else $error("hf gain in tenth dB wrong");
    chk_gain_span: assert property (lf_gain_a <= 8'h42 && hf_gain_b <= 8'h42)
        else $error("gain code beyond span");
    chk_stop_idle: assert property (ss_stop_a |=> ss_ref_a == 0 && !ss_busy_a && !ss_done_a)
        else $error("stop did not idle ramp");
    chk_start_ramp: assert property (ss_start_b && !ss_stop_b |=> ss_busy_b && ss_ref_b == 0)
        else $error("start did not begin ramp");
    chk_ref_step: assert property (ss_busy_a && !ss_start_a && !ss_stop_a |=>
        (ss_ref_a == $past(ss_ref_a) || ss_ref_a == $past(ss_ref_a) + 1'b1))
        else $error("ramp reference jumped");
    chk_done_target: assert property ($rose(ss_done_a) |-> ss_ref_a == TGT && !ss_busy_a)
        else $error("done without target level");
    chk_ref_cap: assert property (ss_ref_a <= TGT)
        else $error("reference above two thirds span");
endmodule

bind lfs_loop_filter_cfg lfs_loop_filter_cfg_assertions #(.REF_W(REF_W)) i_chk (
    .clk_sys(clk_sys), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .ss_start_a(ss_start_a), .ss_stop_a(ss_stop_a),
    .ss_start_b(ss_start_b), .ss_stop_b(ss_stop_b), .ss_ref_a(ss_ref_a), .ss_ref_b(ss_ref_b),
    .ss_busy_a(ss_busy_a), .ss_busy_b(ss_busy_b), .ss_done_a(ss_done_a),
    .lf_gain_a(lf_gain_a), .lf_gain_tenth_db_a(lf_gain_tenth_db_a), .hf_gain_b(hf_gain_b),
    .hf_gain_tenth_db_b(hf_gain_tenth_db_b)
);

// ---- tb/loop_filter_softstart_config_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module loop_filter_softstart_config_tb_top;
    localparam int CYC [4] = '{5460, 8190, 10920, 13650};
    localparam int STEPS = 2730;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [17:0] avs_address = 18'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, ss_done_a, ss_done_b, ss_busy_a, ss_busy_b, gain_err_a, gain_err_b;
    logic light_load_a = 1'b0;
    logic light_load_b = 1'b0;
    logic start_a = 1'b0;
    logic start_b = 1'b0;
    logic stop_a = 1'b0;
    logic stop_b = 1'b0;
    logic [11:0] ss_ref_a, ss_ref_b;
    logic [7:0] lf_a, lf_b, zero_a, zero_b, pole_a, pole_b, hf_a, hf_b, q;
    logic [7:0] lf_db_a, lf_db_b, hf_db_a, hf_db_b;
    int err_count = 0;
    int cmp_count = 0;

    lfs_loop_filter_cfg #(.SS_CYC_0(CYC[0]), .SS_CYC_1(CYC[1]), .SS_CYC_2(CYC[2]),
        .SS_CYC_3(CYC[3])) i_dut (
        .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .light_load_a(light_load_a), .light_load_b(light_load_b), .ss_start_a(start_a),
        .ss_start_b(start_b), .ss_stop_a(stop_a), .ss_stop_b(stop_b), .ss_ref_a(ss_ref_a),
        .ss_ref_b(ss_ref_b), .ss_busy_a(ss_busy_a), .ss_busy_b(ss_busy_b),
        .ss_done_a(ss_done_a), .ss_done_b(ss_done_b), .lf_gain_a(lf_a), .lf_gain_b(lf_b),
        .lf_gain_tenth_db_a(lf_db_a), .lf_gain_tenth_db_b(lf_db_b), .zero_pos_a(zero_a),
        .zero_pos_b(zero_b), .pole_pos_a(pole_a), .pole_pos_b(pole_b), .hf_gain_a(hf_a),
        .hf_gain_b(hf_b), .hf_gain_tenth_db_a(hf_db_a), .hf_gain_tenth_db_b(hf_db_b),
        .gain_err_a(gain_err_a), .gain_err_b(gain_err_b)
    );

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic results;
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 20) begin
            err_count++;
            results();
        end
    endtask

    task automatic t_regs;
        av(1'b0, 16'hfe2c, 8'h0);
        `CHK("reset_value", lfs_pkg::CFG_RESET, q)
        for (int i = 0; i < 12; i++) av(1'b1, 16'hfe2a + 16'(i), 8'h10 + 8'(i));
        for (int i = 0; i < 12; i++) begin
            av(1'b0, 16'hfe2a + 16'(i), 8'h0);
            `CHK("readback", 8'h10 + 8'(i), q)
        end
        av(1'b1, 16'hfe40, 8'h5a);
        av(1'b0, 16'hfe40, 8'h0);
        `CHK("unmapped", 8'h00, q)
    endtask

    task automatic t_coef;
        repeat (2) @(posedge clk_sys);
        `CHK("lf_a", 8'h12, lf_a)
        `CHK("lf_b", 8'h13, lf_b)
        `CHK("zero", 16'h1415, {zero_a, zero_b})
        `CHK("pole", 16'h1617, {pole_a, pole_b})
        `CHK("hf", 16'h1819, {hf_a, hf_b})
        `CHK("lf_db", 16'h3639, {lf_db_a, lf_db_b})
        `CHK("hf_db", 16'h484b, {hf_db_a, hf_db_b})
        light_load_a <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK("ll_lf_a", 8'h1a, lf_a)
        `CHK("ll_lf_db_a", 8'h4e, lf_db_a)
        `CHK("lf_b_kept", 8'h13, lf_b)
        av(1'b0, lfs_pkg::IDX_STATUS, 8'h0);
        `CHK("status_ll", 2'b01, q[5:4])
        light_load_b <= 1'b1;
        light_load_a <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("ll_lf_b", 16'h121b, {lf_a, lf_b})
        av(1'b1, 16'hfe32, 8'h50);
        repeat (2) @(posedge clk_sys);
        `CHK("hf_clamp", 8'h42, hf_a)
        `CHK("gain_err", 1'b1, gain_err_a)
        `CHK("hf_b_kept", 8'h19, hf_b)
        `CHK("hf_db_clamp", 8'hc6, hf_db_a)
        `CHK("gain_err_b", 1'b0, gain_err_b)
        av(1'b0, lfs_pkg::IDX_STATUS, 8'h0);
        `CHK("status_gerr", 2'b01, q[7:6])
    endtask

    task automatic t_ramp(input logic ch, input int code);
        int n;
        int p;
        p = CYC[code] / STEPS;
        av(1'b1, 16'hfe2a + 16'(ch), 8'(code) | (ch ? 8'hfc : 8'h00));
        @(posedge clk_sys);
        if (ch) start_b <= 1'b1;
        else start_a <= 1'b1;
        @(posedge clk_sys);
        start_a <= 1'b0;
        start_b <= 1'b0;
        for (n = 0; n < 20000; n++) begin
            @(posedge clk_sys);
            if ((ch ? ss_done_b : ss_done_a) === 1'b1) break;
        end
        `CHK("ramp_time", 1'b1, (n >= STEPS * p - 3 && n <= STEPS * p + p + 3))
        `CHK("ramp_end", 12'(STEPS), (ch ? ss_ref_b : ss_ref_a))
        `CHK("ramp_busy", 1'b0, (ch ? ss_busy_b : ss_busy_a))
    endtask

    task automatic t_stop;
        @(posedge clk_sys);
        start_a <= 1'b1;
        @(posedge clk_sys);
        start_a <= 1'b0;
        repeat (10) @(posedge clk_sys);
        av(1'b0, lfs_pkg::IDX_STATUS, 8'h0);
        `CHK("status_busy", 1'b1, q[0])
        stop_a <= 1'b1;
        @(posedge clk_sys);
        stop_a <= 1'b0;
        @(posedge clk_sys);
        `CHK("stop_ref", 12'h000, ss_ref_a)
        `CHK("stop_busy", 1'b0, ss_busy_a)
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_coef();
        for (int c = 0; c < 4; c++) t_ramp(1'b0, c);
        t_ramp(1'b1, 2);
        t_stop();
        results();
    end
endmodule
